// ==== qqs_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module qqs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_b,
   input  wire logic                   wrValid,
   input  wire logic [WIDTH-1:0]       wrData,
   output logic                        wrReady,
   output logic                        rdValid,
   output logic [WIDTH-1:0]            rdData,
   input  wire logic                   rdReady,
   output logic [$clog2(DEPTH+1)-1:0]  count
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);

   // refuse sizes the pointer wrap cannot serve
   if (WIDTH < 1 || DEPTH < 2) begin : gBadParam
      $error("qqs_fifo needs WIDTH >= 1 and DEPTH >= 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic [CW-1:0]    count_reg, count_next;
   logic             doWr, doRd;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign wrReady = (count_reg != CW'(DEPTH));
   assign rdValid = (count_reg != '0);
   assign rdData = mem_reg[rdPtr_reg];
   assign count = count_reg;
   assign doWr = wrValid & wrReady;
   assign doRd = rdValid & rdReady;

   always_comb begin
      wrPtr_next = doWr ? bump(wrPtr_reg) : wrPtr_reg;
      rdPtr_next = doRd ? bump(rdPtr_reg) : rdPtr_reg;
      count_next = count_reg;
      if (doWr && !doRd)
         count_next = count_reg + CW'(1);
      else if (doRd && !doWr)
         count_next = count_reg - CW'(1);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         count_reg <= count_next;
      end
   end

   // storage needs no reset; only written slots are ever read
   always_ff @(posedge ref_clk) begin
      if (doWr)
         mem_reg[wrPtr_reg] <= wrData;
   end
endmodule
`default_nettype wire

// ==== qqs_pkg.sv ====
// constants for the egress quality-of-service queue scheduler
// How it works
// RULE1: four transmit queues, highest to lowest
// RULE2: disabled mode forwards without queue selection
// RULE3: strict mode waits for higher queues empty
// RULE4: weighted mode counts, reset eight four two one
// RULE5: first-come mode sends in arrival order
// RULE6: tagged packet queued by priority map lookup
// RULE7: untagged packet takes receiving port priority
// RULE8: port priority 0 to 7, same map
// RULE9: each of eight priorities maps anywhere
// RULE10: reset map priorities 0-3 to low queues
// RULE11: reset map priorities 4-7 to high queues
// RULE12: weighted mode skips empty queue, wraps fresh
// RULE13: arrival order kept within every queue
package qqs_pkg;
   localparam int QUEUES = 4;
   // queue codes, zero is the highest priority
   localparam logic [1:0] Q_HIGHEST = 2'h0;
   localparam logic [1:0] Q_SECOND_HIGH = 2'h1;
   localparam logic [1:0] Q_SECOND_LOW = 2'h2;
   localparam logic [1:0] Q_LOWEST = 2'h3;
   // scheduling modes
   localparam logic [1:0] MODE_DISABLED = 2'h0;
   localparam logic [1:0] MODE_FCFS = 2'h1;
   localparam logic [1:0] MODE_STRICT = 2'h2;
   localparam logic [1:0] MODE_WRR = 2'h3;
   // register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_WEIGHT = 8'h04;
   localparam logic [7:0] OFS_PRIOMAP = 8'h08;
   localparam logic [7:0] OFS_PORTPRIO = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // reset values
   localparam logic [1:0] RST_MODE = 2'h3;
   localparam logic [31:0] RST_WEIGHT = 32'h01020408;
   localparam logic [15:0] RST_PRIOMAP = 16'h05AF;
   localparam logic [23:0] RST_PORTPRIO = 24'h000000;
   // field widths
   localparam int WEIGHT_W = 8;
   localparam int PRIO_W = 3;
   localparam int MAP_W = 2;
endpackage

// ==== qqs_scheduler.sv ====
// classifier, four priority queues and egress scheduler with apb registers
`timescale 1ns/1ns
`default_nettype none
module qqs_scheduler #(
   parameter int DATA_W = 32,
   parameter int DEPTH = 8,
   parameter int PORTS = 8
) (
   input  wire logic                      ref_clk,
   input  wire logic                      rst_b,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      inValid,
   output logic                           inReady,
   input  wire logic [DATA_W-1:0]         inData,
   input  wire logic                      inTagged,
   input  wire logic [2:0]                inTagPrio,
   input  wire logic [$clog2(PORTS)-1:0]  inPort,
   output logic                           outValid,
   input  wire logic                      outReady,
   output logic [DATA_W-1:0]              outData,
   output logic [1:0]                     outQueue
);
   localparam int PW = $clog2(PORTS);
   localparam int CW = $clog2(DEPTH+1);
   localparam int ODEPTH = 4 * DEPTH;

   // port priority register only has room for eight ports
   if (PORTS < 2 || PORTS > 8 || DATA_W < 1 || DEPTH < 2) begin : gBadParam
      $error("qqs_scheduler: PORTS 2..8, DATA_W >= 1, DEPTH >= 2");
   end

   // ---------------- registers ----------------
   logic [1:0]  mode_reg, mode_next;
   logic [31:0] weight_reg, weight_next;
   logic [15:0] map_reg, map_next;
   logic [23:0] portPrio_reg, portPrio_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   logic        apbSetup, apbWrite, mapped;
   logic [4*CW-1:0] fillVec;

   function automatic logic [1:0] mapLookup(input logic [15:0] m,
                                            input logic [2:0] p);
      mapLookup = m[2*p +: 2];
   endfunction

   function automatic logic [7:0] weightOf(input logic [31:0] w,
                                           input logic [1:0] q);
      weightOf = w[8*q +: 8];
   endfunction

   assign apbSetup = psel & ~penable;
   assign apbWrite = psel & penable & pready_reg & pwrite & ~pslverr_reg;
   assign mapped = (paddr == qqs_pkg::OFS_MODE)
                 | (paddr == qqs_pkg::OFS_WEIGHT)
                 | (paddr == qqs_pkg::OFS_PRIOMAP)
                 | (paddr == qqs_pkg::OFS_PORTPRIO)
                 | (paddr == qqs_pkg::OFS_STATUS);

   always_comb begin
      mode_next = mode_reg;
      weight_next = weight_reg;
      map_next = map_reg;
      portPrio_next = portPrio_reg;
      // one wait-free access phase: answer is prepared during setup
      pready_next = apbSetup;
      pslverr_next = apbSetup & ~mapped;
      prdata_next = '0;
      if (apbSetup && !pwrite) begin
         unique case (paddr)
            qqs_pkg::OFS_MODE:     prdata_next = {30'h0, mode_reg};
            qqs_pkg::OFS_WEIGHT:   prdata_next = weight_reg;
            qqs_pkg::OFS_PRIOMAP:  prdata_next = {16'h0, map_reg};
            qqs_pkg::OFS_PORTPRIO: prdata_next = {8'h0, portPrio_reg};
            qqs_pkg::OFS_STATUS:   prdata_next = 32'(fillVec);
            default:               prdata_next = '0;
         endcase
      end
      if (apbWrite) begin
         unique case (paddr)
            qqs_pkg::OFS_MODE:     mode_next = pwdata[1:0];
            qqs_pkg::OFS_WEIGHT:   weight_next = pwdata;
            // RULE9 map any level
            qqs_pkg::OFS_PRIOMAP:  map_next = pwdata[15:0];
            // RULE8 port priority store
            qqs_pkg::OFS_PORTPRIO: portPrio_next = pwdata[23:0];
            default:               mode_next = mode_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         mode_reg <= qqs_pkg::RST_MODE;
         // RULE4 default weights
         weight_reg <= qqs_pkg::RST_WEIGHT;
         // RULE10 RULE11 default map
         map_reg <= qqs_pkg::RST_PRIOMAP;
         portPrio_reg <= qqs_pkg::RST_PORTPRIO;
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         weight_reg <= weight_next;
         map_reg <= map_next;
         portPrio_reg <= portPrio_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ---------------- classifier stage ----------------
   logic              holdValid_reg, holdValid_next;
   logic [DATA_W-1:0] holdData_reg, holdData_next;
   logic [1:0]        holdQ_reg, holdQ_next;
   logic              inReady_reg, inReady_next;
   logic              capture, push, useOrder;
   logic [2:0]        pktPrio;
   logic [3:0]        qWrReady, qValid, popQ;
   logic [DATA_W-1:0] qData [4];
   logic              ordWrReady, ordValid;
   logic [1:0]        ordHead;

   assign useOrder = (mode_reg == qqs_pkg::MODE_DISABLED)
                   | (mode_reg == qqs_pkg::MODE_FCFS);
   assign capture = inValid & inReady_reg;
   assign push = holdValid_reg & qWrReady[holdQ_reg]
               & (~useOrder | ordWrReady);

   always_comb begin
      // RULE6 RULE7 tag or port priority
      pktPrio = inTagged ? inTagPrio
                         : portPrio_reg[3*inPort +: 3];
      holdValid_next = holdValid_reg & ~push;
      holdData_next = holdData_reg;
      holdQ_next = holdQ_reg;
      if (capture) begin
         holdValid_next = 1'b1;
         holdData_next = inData;
         // RULE2 no queue selection
         if (mode_reg == qqs_pkg::MODE_DISABLED)
            holdQ_next = qqs_pkg::Q_LOWEST;
         else
            holdQ_next = mapLookup(map_reg, pktPrio);
      end
      // stall the fabric while the held packet cannot be queued
      inReady_next = ~holdValid_next;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         holdValid_reg <= 1'b0;
         holdData_reg <= '0;
         holdQ_reg <= qqs_pkg::Q_LOWEST;
         inReady_reg <= 1'b0;
      end else begin
         holdValid_reg <= holdValid_next;
         holdData_reg <= holdData_next;
         holdQ_reg <= holdQ_next;
         inReady_reg <= inReady_next;
      end
   end

   assign inReady = inReady_reg;

   // ---------------- queues ----------------
   // RULE1 RULE13 four fifo queues
   for (genvar g = 0; g < qqs_pkg::QUEUES; g++) begin : gQueue
      qqs_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) uQueue (
         .ref_clk (ref_clk),
         .rst_b   (rst_b),
         .wrValid (holdValid_reg & (holdQ_reg == 2'(g))
                   & (~useOrder | ordWrReady)),
         .wrData  (holdData_reg),
         .wrReady (qWrReady[g]),
         .rdValid (qValid[g]),
         .rdData  (qData[g]),
         .rdReady (popQ[g]),
         .count   (fillVec[CW*g +: CW])
      );
   end

   // RULE5 arrival order record
   qqs_fifo #(.WIDTH(2), .DEPTH(ODEPTH)) uOrder (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wrValid (holdValid_reg & useOrder & qWrReady[holdQ_reg]),
      .wrData  (holdQ_reg),
      .wrReady (ordWrReady),
      .rdValid (ordValid),
      .rdData  (ordHead),
      .rdReady (useOrder & (|popQ)),
      .count   ()
   );

   // ---------------- scheduler ----------------
   logic [1:0]        wrrIdx_reg, wrrIdx_next;
   logic [7:0]        credit_reg, credit_next;
   logic              outValid_reg, outValid_next;
   logic [DATA_W-1:0] outData_reg, outData_next;
   logic [1:0]        outQueue_reg, outQueue_next;
   logic              canLoad, selValid;
   logic [1:0]        sel;

   assign canLoad = ~outValid_reg | outReady;

   always_comb begin
      sel = qqs_pkg::Q_HIGHEST;
      selValid = 1'b0;
      wrrIdx_next = wrrIdx_reg;
      credit_next = credit_reg;
      unique case (mode_reg)
         qqs_pkg::MODE_STRICT: begin
            // RULE3 highest non-empty first
            for (int i = qqs_pkg::QUEUES - 1; i >= 0; i--) begin
               if (qValid[i]) begin
                  sel = 2'(i);
                  selValid = 1'b1;
               end
            end
         end
         qqs_pkg::MODE_WRR: begin
            sel = wrrIdx_reg;
            // RULE4 send up to weight
            selValid = qValid[wrrIdx_reg] & (credit_reg != 8'h00);
            if (canLoad) begin
               if (selValid && credit_reg != 8'h01) begin
                  credit_next = credit_reg - 8'h01;
               end else begin
                  // RULE12 skip empty, wrap fresh
                  wrrIdx_next = wrrIdx_reg + 2'h1;
                  credit_next = weightOf(weight_reg, wrrIdx_reg + 2'h1);
               end
            end
         end
         default: begin
            // RULE5 oldest packet first
            sel = ordHead;
            selValid = ordValid & qValid[ordHead];
         end
      endcase
      popQ = (canLoad & selValid) ? (4'h1 << sel) : 4'h0;
      outValid_next = outValid_reg & ~outReady;
      outData_next = outData_reg;
      outQueue_next = outQueue_reg;
      if (canLoad && selValid) begin
         outValid_next = 1'b1;
         outData_next = qData[sel];
         outQueue_next = sel;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wrrIdx_reg <= qqs_pkg::Q_HIGHEST;
         credit_reg <= qqs_pkg::RST_WEIGHT[7:0];
         outValid_reg <= 1'b0;
         outData_reg <= '0;
         outQueue_reg <= qqs_pkg::Q_HIGHEST;
      end else begin
         wrrIdx_reg <= wrrIdx_next;
         credit_reg <= credit_next;
         outValid_reg <= outValid_next;
         outData_reg <= outData_next;
         outQueue_reg <= outQueue_next;
      end
   end

   assign outValid = outValid_reg;
   assign outData = outData_reg;
   assign outQueue = outQueue_reg;

   // ---------------- checks ----------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   AST_ONE_QUEUE: assert property ($onehot0(popQ)) // RULE1
      else $error("more than one queue popped");
   AST_STRICT: assert property ( // RULE3
      (mode_reg == qqs_pkg::MODE_STRICT && |popQ)
      |-> ((qValid & ((4'h1 << sel) - 4'h1)) == 4'h0))
      else $error("strict mode skipped a busier higher queue");
   AST_WRR_TURN: assert property ( // RULE4
      (mode_reg == qqs_pkg::MODE_WRR && |popQ)
      |-> (sel == wrrIdx_reg && credit_reg != 8'h00))
      else $error("weighted pop outside current turn");
   AST_WRR_SKIP: assert property ( // RULE12
      (mode_reg == qqs_pkg::MODE_WRR && canLoad && !qValid[wrrIdx_reg]
       && mode_next == qqs_pkg::MODE_WRR)
      |=> (wrrIdx_reg == $past(wrrIdx_reg) + 2'h1
           && credit_reg == weightOf(weight_reg, wrrIdx_reg)))
      else $error("empty weighted queue not skipped with fresh count");
   AST_ORDER: assert property ( // RULE5
      (useOrder && |popQ) |-> (sel == ordHead))
      else $error("first-come pop not oldest packet");
   AST_DISABLED: assert property ( // RULE2
      (capture && mode_reg == qqs_pkg::MODE_DISABLED)
      |=> (holdQ_reg == qqs_pkg::Q_LOWEST))
      else $error("disabled mode selected a queue");
   AST_TAGGED: assert property ( // RULE6
      (capture && inTagged && mode_reg != qqs_pkg::MODE_DISABLED)
      |=> (holdQ_reg == mapLookup($past(map_reg), $past(inTagPrio))))
      else $error("tagged packet in wrong queue");
   AST_UNTAGGED: assert property ( // RULE7
      (capture && !inTagged && mode_reg != qqs_pkg::MODE_DISABLED)
      |=> (holdQ_reg == mapLookup($past(map_reg),
           $past(portPrio_reg[3*inPort +: 3]))))
      else $error("untagged packet ignored port priority");
   AST_RESET_MAP: assert property ( // RULE10
      $past(!rst_b) |-> (map_reg == 16'h05AF
                         && weight_reg == 32'h01020408))
      else $error("map or weights wrong after reset");
   AST_OUT_HOLD: assert property ( // RULE13
      (outValid && !outReady) |=> ($stable(outData) && outValid))
      else $error("output packet dropped under back-pressure");
endmodule
`default_nettype wire

// ==== qqs_tx_sink.sv ====
// transmit-side model: takes offered packets, can stall or pace itself
`timescale 1ns/1ns
`default_nettype none
module qqs_tx_sink #(
   parameter int DATA_W = 32
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic              stall,
   input  wire logic              slow,
   input  wire logic              outValid,
   input  wire logic [DATA_W-1:0] outData,
   input  wire logic [1:0]        outQueue,
   output logic                   outReady
);
   logic [DATA_W+1:0] got [$];
   // ready changes only after an edge, like a real mac; slow halves the rate
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         outReady <= 1'b0;
      end else begin
         if (outValid && outReady) begin
            got.push_back({outQueue, outData});
         end
         outReady <= !stall && !(slow && outReady);
      end
   end
endmodule
`default_nettype wire

// ==== test_qos_queue_scheduler.sv ====
// self-checking bench for the egress queue scheduler
`timescale 1ns/1ns
`default_nettype none
module test_qos_queue_scheduler;
   logic        ref_clk;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        inValid;
   logic        inReady;
   logic [31:0] inData;
   logic        inTagged;
   logic [2:0]  inTagPrio;
   logic [2:0]  inPort;
   logic        outValid;
   logic        outReady;
   logic [31:0] outData;
   logic [1:0]  outQueue;
   logic        stall;
   logic        slow;
   logic [15:0] mapM;
   logic [23:0] portM;
   logic [31:0] seq;
   logic [33:0] pend [4][$];
   logic [33:0] arr [$];
   int          wM [4];
   int          base;
   int          cyc;
   int          err_total;
   int          tests_run;

   qqs_scheduler #(.DATA_W(32), .DEPTH(8), .PORTS(8)) u_dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .inValid(inValid),
      .inReady(inReady), .inData(inData), .inTagged(inTagged),
      .inTagPrio(inTagPrio), .inPort(inPort), .outValid(outValid),
      .outReady(outReady), .outData(outData), .outQueue(outQueue));

   qqs_tx_sink #(.DATA_W(32)) u_sink (
      .ref_clk(ref_clk), .rst_b(rst_b), .stall(stall), .slow(slow),
      .outValid(outValid), .outData(outData), .outQueue(outQueue),
      .outReady(outReady));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         test_done();
      end
   end

   task automatic chk(input string what, input logic [33:0] seen,
                      input logic [33:0] want);
      tests_run++;
      if (seen !== want) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // answer taken only at the edge that sees pready high
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1) err_total++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] want,
                        input logic wantErr);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      chk("prdata", {2'h0, rd}, {2'h0, want});
      chk("pslverr", {33'h0, err}, {33'h0, wantErr});
   endtask

   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
      chk("write pslverr", {33'h0, err}, 34'h0);
   endtask

   task automatic send(input logic tg, input logic [2:0] tp,
                       input logic [2:0] pt);
      logic [2:0]  p;
      logic [1:0]  q;
      logic [33:0] pk;
      int          n;
      p = tg ? tp : portM[3*pt +: 3];
      q = mapM[2*p +: 2];
      seq = seq + 32'h1;
      pk = {q, 32'hC0DE0000 + seq};
      pend[q].push_back(pk);
      arr.push_back(pk);
      n = 0;
      @(posedge ref_clk);
      inValid <= 1'b1;
      inData <= pk[31:0];
      inTagged <= tg;
      inTagPrio <= tp;
      inPort <= pt;
      // the packet is taken at the edge that sees inReady high
      do begin
         @(posedge ref_clk);
         n++;
      end while (inReady !== 1'b1 && n < 200);
      if (inReady !== 1'b1) err_total++;
      inValid <= 1'b0;
   endtask

   // builds the expected output order, then lets the sink take it all
   task automatic drain(input logic [1:0] md);
      logic [33:0] e [$];
      int          q;
      int          t;
      int          n;
      if (md == qqs_pkg::MODE_FCFS || md == qqs_pkg::MODE_DISABLED) begin
         foreach (arr[i]) begin
            e.push_back(md == qqs_pkg::MODE_FCFS ? arr[i] :
                        {qqs_pkg::Q_LOWEST, arr[i][31:0]});
         end
         for (q = 0; q < 4; q++) pend[q].delete();
      end else begin
         while (pend[0].size() + pend[1].size() + pend[2].size()
                + pend[3].size() > 0) begin
            for (q = 0; q < 4; q++) begin
               t = (md == qqs_pkg::MODE_STRICT) ? 99 : wM[q];
               while (t > 0 && pend[q].size() > 0) begin
                  e.push_back(pend[q].pop_front());
                  t--;
               end
            end
         end
      end
      arr.delete();
      n = 0;
      @(posedge ref_clk);
      stall <= 1'b0;
      while (u_sink.got.size() < base + e.size() && n < 500) begin
         @(posedge ref_clk);
         n++;
      end
      repeat (4) @(posedge ref_clk);
      stall <= 1'b1;
      chk("count", 34'(u_sink.got.size()), 34'(base + e.size()));
      // in-queue order is part of every expected list
      foreach (e[i]) chk("packet", u_sink.got[base + i], e[i]);
      base = base + e.size();
   endtask

   task automatic mixed();
      send(1'b1, 3'h0, 3'h0);
      send(1'b1, 3'h4, 3'h1);
      send(1'b1, 3'h3, 3'h1);
      send(1'b1, 3'h7, 3'h1);
      send(1'b0, 3'h1, 3'h7);
   endtask

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      inValid = 1'b0;
      inData = 32'h0;
      inTagged = 1'b0;
      inTagPrio = 3'h0;
      inPort = 3'h0;
      stall = 1'b1;
      slow = 1'b0;
      mapM = 16'h05AF;
      portM = 24'h0;
      wM = '{8, 4, 2, 1};
      seq = 32'h0;
      base = 0;
      cyc = 0;
      err_total = 0;
      tests_run = 0;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      rdChk(qqs_pkg::OFS_MODE, 32'h3, 1'b0); // default weighted
      rdChk(qqs_pkg::OFS_WEIGHT, 32'h01020408, 1'b0);
      rdChk(qqs_pkg::OFS_PRIOMAP, 32'h05AF, 1'b0);
      rdChk(qqs_pkg::OFS_PORTPRIO, 32'h0, 1'b0);
      rdChk(8'h20, 32'h0, 1'b1);
      wrReg(qqs_pkg::OFS_STATUS, 32'hFFFFFFFF);
      rdChk(qqs_pkg::OFS_STATUS, 32'h0, 1'b0);
      // highest queue kept busy so the turn pointer is known at drain
      repeat (8) send(1'b1, 3'h6, 3'h0);
      repeat (3) send(1'b1, 3'h2, 3'h1);
      repeat (2) send(1'b1, 3'h1, 3'h2);
      slow <= 1'b1;
      drain(qqs_pkg::MODE_WRR);
      slow <= 1'b0;
      wrReg(qqs_pkg::OFS_MODE, {30'h0, qqs_pkg::MODE_STRICT});
      for (int p = 7; p >= 0; p--) send(1'b1, 3'(p), 3'h5);
      drain(qqs_pkg::MODE_STRICT);
      wrReg(qqs_pkg::OFS_PRIOMAP, 32'h4E1B);
      mapM = 16'h4E1B;
      wrReg(qqs_pkg::OFS_PORTPRIO, 32'h00A00180);
      portM = 24'hA00180;
      rdChk(qqs_pkg::OFS_PORTPRIO, 32'h00A00180, 1'b0);
      send(1'b1, 3'h3, 3'h0);
      send(1'b0, 3'h4, 3'h2);
      send(1'b0, 3'h1, 3'h7);
      send(1'b0, 3'h7, 3'h0);
      send(1'b1, 3'h7, 3'h2);
      send(1'b1, 3'h4, 3'h7);
      drain(qqs_pkg::MODE_STRICT);
      wrReg(qqs_pkg::OFS_WEIGHT, 32'h01030102);
      wM = '{2, 1, 3, 1};
      wrReg(qqs_pkg::OFS_MODE, {30'h0, qqs_pkg::MODE_WRR});
      repeat (5) send(1'b1, 3'h3, 3'h0);
      repeat (2) send(1'b1, 3'h7, 3'h0);
      repeat (4) send(1'b1, 3'h4, 3'h0);
      drain(qqs_pkg::MODE_WRR);
      wrReg(qqs_pkg::OFS_MODE, {30'h0, qqs_pkg::MODE_FCFS});
      mixed();
      drain(qqs_pkg::MODE_FCFS);
      wrReg(qqs_pkg::OFS_MODE, {30'h0, qqs_pkg::MODE_DISABLED});
      mixed();
      drain(qqs_pkg::MODE_DISABLED);
      rdChk(qqs_pkg::OFS_STATUS, 32'h0, 1'b0);
      test_done();
   end
endmodule
`default_nettype wire
